// ---- bmd_decode.sv ----
// Purpose: Memory address decode of a PCI-to-ISA bridge with an APB register file.
// Assumes: Request inputs are synchronous to clock_i; results appear one cycle later.
// Notes: Every output comes from a flip-flop.
`timescale 1ns/1ps
`include "bmd_defs.svh"

module bmd_decode
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire bmd_pkg::bmd_word_type paddr_i,
   input wire bmd_pkg::bmd_word_type pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic pready_o,
   output bmd_pkg::bmd_word_type prdata_o,
   output logic pslverr_o,
   // PCI master memory access.
   input wire logic pci_req_valid_i,
   input wire logic pci_write_i,
   input wire bmd_pkg::bmd_word_type pci_addr_i,
   output logic main_memory_select_n_o,
   output logic bios_positive_decode_o,
   // ISA master or DMA memory cycle.
   input wire logic isa_req_valid_i,
   input wire bmd_pkg::bmd_word_type isa_addr_i,
   output logic isa_forward_pci_o,
   output logic isa_keep_isa_o
);
   import bmd_pkg::*;

   bmd_reg_type mcs_ctrl_r;
   bmd_reg_type mcs_hole_bot_r;
   bmd_reg_type mcs_hole_top_r;
   bmd_reg_type mcs_tom_r;
   bmd_reg_type isa_fwd_ctrl_r;
   bmd_reg_type isa_rom_en_r;
   bmd_reg_type isa_hole_bot_r;
   bmd_reg_type isa_hole_top_r;
   bmd_reg_type decode_aux_r;
   bmd_phase_type phase_r;
   bmd_phase_type phase_nxt;
   logic pci_hole_hit_r;
   logic isa_hole_hit_r;

   // APB decode: word index from address bits 9:2, anything else unmapped.
   wire [7:0] word_idx = paddr_i[9:2];
   wire addr_aligned = (paddr_i[31:10] == 22'h000000) && (paddr_i[1:0] == 2'h0);
   wire hit_ctrl = addr_aligned && (word_idx == `BMD_IDX_MCS_CTRL);
   wire hit_hbot = addr_aligned && (word_idx == `BMD_IDX_MCS_HOLE_BOT);
   wire hit_htop = addr_aligned && (word_idx == `BMD_IDX_MCS_HOLE_TOP);
   wire hit_tom = addr_aligned && (word_idx == `BMD_IDX_MCS_TOM);
   wire hit_fwd = addr_aligned && (word_idx == `BMD_IDX_ISA_FWD_CTRL);
   wire hit_rom = addr_aligned && (word_idx == `BMD_IDX_ISA_ROM_EN);
   wire hit_ihbot = addr_aligned && (word_idx == `BMD_IDX_ISA_HOLE_BOT);
   wire hit_ihtop = addr_aligned && (word_idx == `BMD_IDX_ISA_HOLE_TOP);
   wire hit_aux = addr_aligned && (word_idx == `BMD_IDX_DECODE_AUX);
   wire hit_stat = addr_aligned && (word_idx == `BMD_IDX_DECODE_STATUS);
   wire hit_any = hit_ctrl | hit_hbot | hit_htop | hit_tom | hit_fwd | hit_rom |
                  hit_ihbot | hit_ihtop | hit_aux | hit_stat;

   // A write lands only at the access edge where pready is seen high, and only with lane 0 enabled.
   wire setup_cycle = psel_i && !penable_i;
   wire wr_commit = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && !pslverr_o;
   wire [7:0] wr_byte = pwdata_i[7:0];

   // Status register shows the block's own last decode results; it is read-only.
   wire [7:0] status_byte = {4'h0, isa_hole_hit_r, pci_hole_hit_r, isa_forward_pci_o,
                             !main_memory_select_n_o};

   // Read mux; reserved control bits 7:5 read as zero because they are never stored.
   wire [7:0] rd_byte = hit_ctrl ? mcs_ctrl_r :
                        hit_hbot ? mcs_hole_bot_r :
                        hit_htop ? mcs_hole_top_r :
                        hit_tom ? mcs_tom_r :
                        hit_fwd ? isa_fwd_ctrl_r :
                        hit_rom ? isa_rom_en_r :
                        hit_ihbot ? isa_hole_bot_r :
                        hit_ihtop ? isa_hole_top_r :
                        hit_aux ? decode_aux_r :
                        hit_stat ? status_byte : 8'h00;

   // Phase walk; the answer is always ready on the first access cycle, so no wait states.
   always_comb
   begin
      case (phase_r)
         BMD_PH_IDLE: phase_nxt = setup_cycle ? BMD_PH_SETUP : BMD_PH_IDLE;
         BMD_PH_SETUP: phase_nxt = BMD_PH_ACCESS;
         BMD_PH_ACCESS: phase_nxt = setup_cycle ? BMD_PH_SETUP : BMD_PH_IDLE;
         default: phase_nxt = BMD_PH_IDLE;
      endcase
   end

   // APB answer flops: data and error are latched in the setup cycle and held through access.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         phase_r <= BMD_PH_IDLE;
         pready_o <= 1'b0;
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
      end
      else
      begin
         phase_r <= phase_nxt;
         pready_o <= setup_cycle;
         if (setup_cycle)
         begin
            prdata_o <= pwrite_i ? 32'h00000000 : {24'h000000, rd_byte};
            pslverr_o <= !hit_any || (pwrite_i && hit_stat);
         end
      end
   end

   // Configuration registers; reserved bits of the control register are never stored.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mcs_ctrl_r <= `BMD_RST_MCS_CTRL;
         mcs_hole_bot_r <= `BMD_RST_HOLE_BOT;
         mcs_hole_top_r <= `BMD_RST_HOLE_TOP;
         mcs_tom_r <= `BMD_RST_MCS_TOM;
         isa_fwd_ctrl_r <= `BMD_RST_ISA_FWD_CTRL;
         isa_rom_en_r <= `BMD_RST_ISA_ROM_EN;
         isa_hole_bot_r <= `BMD_RST_HOLE_BOT;
         isa_hole_top_r <= `BMD_RST_HOLE_TOP;
         decode_aux_r <= `BMD_RST_DECODE_AUX;
      end
      else if (wr_commit)
      begin
         if (hit_ctrl) mcs_ctrl_r <= {3'h0, wr_byte[4:0]};
         if (hit_hbot) mcs_hole_bot_r <= wr_byte;
         if (hit_htop) mcs_hole_top_r <= wr_byte;
         if (hit_tom) mcs_tom_r <= wr_byte;
         if (hit_fwd) isa_fwd_ctrl_r <= wr_byte;
         if (hit_rom) isa_rom_en_r <= wr_byte;
         if (hit_ihbot) isa_hole_bot_r <= wr_byte;
         if (hit_ihtop) isa_hole_top_r <= wr_byte;
         if (hit_aux) decode_aux_r <= {6'h00, wr_byte[1:0]};
      end
   end

   // PCI side segment decode below 1 MB.
   wire master_en = mcs_ctrl_r[`BMD_CTRL_MASTER];
   wire pci_low = (pci_addr_i[31:19] == `BMD_TAG_LOW_512K);
   wire pci_mid = (pci_addr_i[31:17] == `BMD_TAG_MID_128K);
   wire pci_bios = (pci_addr_i[31:16] == `BMD_TAG_UPPER_BIOS);
   // The 512-640 KB and upper BIOS segments each pick their write or read enable; both clear means no select at all.
   wire mid_ok = pci_write_i ? mcs_ctrl_r[`BMD_CTRL_MID_WE] : mcs_ctrl_r[`BMD_CTRL_MID_RD];
   wire bios_ok = pci_write_i ? mcs_ctrl_r[`BMD_CTRL_BIOS_WE] : mcs_ctrl_r[`BMD_CTRL_BIOS_RD];

   // Region from 2 MB up to the boundary: a code of v covers 2 MB steps 1..v, so 00h is empty.
   wire pci_tom = (pci_addr_i[31:29] == 3'h0) && (pci_addr_i[28:21] != 8'h00) &&
                  (pci_addr_i[28:21] <= mcs_tom_r);

   // Hole: inclusive bounds on bits 23:16, only under 16 MB; top below bottom matches nothing.
   wire pci_hole = (pci_addr_i[31:24] == 8'h00) &&
                   (pci_addr_i[23:16] >= mcs_hole_bot_r) && (pci_addr_i[23:16] <= mcs_hole_top_r);

   // The lowest 512 KB has no enables of its own and follows the master enable alone.
   wire pci_region = pci_low || (pci_mid && mid_ok) || (pci_bios && bios_ok) || pci_tom;
   wire pci_select = pci_req_valid_i && master_en && pci_region && !pci_hole;

   // ISA side: 1 MB up to (n+1) MB, so code 0 leaves the region empty.
   wire [3:0] isa_top = isa_fwd_ctrl_r[7:4];
   wire isa_upper = (isa_addr_i[31:24] == 8'h00) && (isa_addr_i[23:20] != 4'h0) &&
                    (isa_addr_i[23:20] <= isa_top);
   wire isa_hole = (isa_addr_i[31:24] == 8'h00) &&
                   (isa_addr_i[23:16] >= isa_hole_bot_r) && (isa_addr_i[23:16] <= isa_hole_top_r);
   wire isa_low = (isa_addr_i[31:19] == `BMD_TAG_LOW_512K) && isa_fwd_ctrl_r[`BMD_FWD_LOW];
   wire isa_mid = (isa_addr_i[31:17] == `BMD_TAG_MID_128K) && isa_fwd_ctrl_r[`BMD_FWD_MID];
   wire isa_vga = (isa_addr_i[31:17] == `BMD_TAG_VGA_128K) && isa_fwd_ctrl_r[`BMD_FWD_VGA];
   // The boot ROM select enable wins over the low BIOS forward enable.
   wire isa_lbios = (isa_addr_i[31:16] == `BMD_TAG_LOW_BIOS) && isa_fwd_ctrl_r[`BMD_FWD_LOW_BIOS] &&
                    !decode_aux_r[`BMD_AUX_BOOT_ROM];
   // ROM area blocks of 16 KB are picked by address bits 16:14.
   wire isa_rom = (isa_addr_i[31:17] == `BMD_TAG_ROM_128K) && isa_rom_en_r[isa_addr_i[16:14]];
   wire isa_forward = isa_req_valid_i &&
                      ((isa_upper && !isa_hole) || isa_low || isa_mid || isa_vga || isa_lbios || isa_rom);

   // Decode result flops; the select is held deasserted while no request is presented.
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         main_memory_select_n_o <= 1'b1;
         bios_positive_decode_o <= 1'b1;
         isa_forward_pci_o <= 1'b0;
         isa_keep_isa_o <= 1'b0;
         pci_hole_hit_r <= 1'b0;
         isa_hole_hit_r <= 1'b0;
      end
      else
      begin
         main_memory_select_n_o <= !pci_select;
         // Positive upper BIOS decode only while the memory select function is off.
         bios_positive_decode_o <= decode_aux_r[`BMD_AUX_POS_BIOS] && !master_en;
         isa_forward_pci_o <= isa_forward;
         isa_keep_isa_o <= isa_req_valid_i && !isa_forward;
         pci_hole_hit_r <= pci_req_valid_i && pci_hole;
         isa_hole_hit_r <= isa_req_valid_i && isa_hole;
      end
   end

   // Checks. The memory decode checks compare against address slices computed here, not the decode wires above.
   default clocking bmd_cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   wire chk_in_hole = (pci_addr_i[31:24] == 8'h00) && (mcs_hole_top_r >= mcs_hole_bot_r) &&
                      (pci_addr_i[23:16] >= mcs_hole_bot_r) && (pci_addr_i[23:16] <= mcs_hole_top_r);

   property p_master_off;
      !mcs_ctrl_r[`BMD_CTRL_MASTER] |=> main_memory_select_n_o;
   endproperty
   a_master_off: assert property (p_master_off) else $error("Select asserted with master disabled.");

   property p_subtractive_bios;
      mcs_ctrl_r[`BMD_CTRL_MASTER] |=> !bios_positive_decode_o;
   endproperty
   a_subtractive_bios: assert property (p_subtractive_bios) else $error("Positive BIOS decode kept.");

   property p_low_segment;
      pci_req_valid_i && mcs_ctrl_r[`BMD_CTRL_MASTER] && (pci_addr_i < 32'h00080000)
         && !chk_in_hole |=> !main_memory_select_n_o;
   endproperty
   a_low_segment: assert property (p_low_segment) else $error("Low 512 KB not selected.");

   property p_bios_write;
      pci_req_valid_i && pci_write_i && (pci_addr_i[31:16] == 16'h000F)
         && !mcs_ctrl_r[`BMD_CTRL_BIOS_WE] |=> main_memory_select_n_o;
   endproperty
   a_bios_write: assert property (p_bios_write) else $error("BIOS write selected while disabled.");

   property p_bios_read;
      pci_req_valid_i && !pci_write_i && (pci_addr_i[31:16] == 16'h000F) && mcs_ctrl_r[`BMD_CTRL_MASTER]
         && mcs_ctrl_r[`BMD_CTRL_BIOS_RD] && !chk_in_hole |=> !main_memory_select_n_o;
   endproperty
   a_bios_read: assert property (p_bios_read) else $error("BIOS read not selected.");

   property p_mid_denied;
      pci_req_valid_i && (pci_addr_i[31:17] == 15'h0004) && !mcs_ctrl_r[`BMD_CTRL_MID_WE]
         && !mcs_ctrl_r[`BMD_CTRL_MID_RD] |=> main_memory_select_n_o;
   endproperty
   a_mid_denied: assert property (p_mid_denied) else $error("Disabled 512-640 KB selected.");

   property p_hole;
      pci_req_valid_i && chk_in_hole |=> main_memory_select_n_o;
   endproperty
   a_hole: assert property (p_hole) else $error("Select asserted inside the hole.");

   property p_tom;
      pci_req_valid_i && mcs_ctrl_r[`BMD_CTRL_MASTER] && (pci_addr_i[31:29] == 3'h0)
         && (pci_addr_i[28:21] != 8'h00) && (pci_addr_i[28:21] <= mcs_tom_r) && !chk_in_hole
         |=> !main_memory_select_n_o;
   endproperty
   a_tom: assert property (p_tom) else $error("Top of memory region not selected.");

   property p_tom_zero;
      pci_req_valid_i && (mcs_tom_r == 8'h00) && (pci_addr_i >= 32'h00200000) |=> main_memory_select_n_o;
   endproperty
   a_tom_zero: assert property (p_tom_zero) else $error("Zero boundary still selects.");

   property p_isa_region;
      isa_req_valid_i && (isa_addr_i[31:24] == 8'h00) && (isa_addr_i[23:20] != 4'h0)
         && (isa_addr_i[23:20] <= isa_fwd_ctrl_r[7:4])
         && !((isa_addr_i[23:16] >= isa_hole_bot_r) && (isa_addr_i[23:16] <= isa_hole_top_r))
         |=> isa_forward_pci_o;
   endproperty
   a_isa_region: assert property (p_isa_region) else $error("ISA region cycle not forwarded.");

   property p_isa_hole;
      isa_req_valid_i && (isa_addr_i[31:20] != 12'h000) && (isa_addr_i[31:24] == 8'h00)
         && (isa_addr_i[23:16] >= isa_hole_bot_r) && (isa_addr_i[23:16] <= isa_hole_top_r)
         |=> !isa_forward_pci_o ##1 1'b1;
   endproperty
   a_isa_hole: assert property (p_isa_hole) else $error("ISA hole cycle forwarded.");

   property p_boot_rom;
      isa_req_valid_i && (isa_addr_i[31:16] == 16'h000E) && decode_aux_r[`BMD_AUX_BOOT_ROM]
         |=> isa_keep_isa_o && !isa_forward_pci_o;
   endproperty
   a_boot_rom: assert property (p_boot_rom) else $error("Low BIOS left ISA under boot ROM select.");

   property p_rom_block;
      isa_req_valid_i && (isa_addr_i[31:17] == 15'h0006)
         |=> isa_forward_pci_o == $past(isa_rom_en_r[isa_addr_i[16:14]]);
   endproperty
   a_rom_block: assert property (p_rom_block) else $error("ROM block forward mismatch.");

   property p_low_fwd;
      isa_req_valid_i && (isa_addr_i[31:19] == 13'h0000) |=> isa_forward_pci_o == $past(isa_fwd_ctrl_r[0]);
   endproperty
   a_low_fwd: assert property (p_low_fwd) else $error("Low 512 KB forward mismatch.");

   property p_isa_exclusive;
      isa_req_valid_i |=> (isa_forward_pci_o ^ isa_keep_isa_o);
   endproperty
   a_isa_exclusive: assert property (p_isa_exclusive) else $error("ISA cycle has no single owner.");

   property p_apb_answer;
      psel_i && !penable_i |=> pready_o ##1 !pready_o || (psel_i && !penable_i);
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("APB answer not one cycle after setup.");

   property p_apb_write;
      wr_commit && hit_tom |=> mcs_tom_r == $past(pwdata_i[7:0]);
   endproperty
   a_apb_write: assert property (p_apb_write) else $error("Boundary write not stored.");

   // A cycle with no request must leave the select high and both ISA answers low.
   property p_idle_pci;
      !pci_req_valid_i |=> main_memory_select_n_o;
   endproperty
   a_idle_pci: assert property (p_idle_pci) else $error("Select asserted with no request.");

   property p_idle_isa;
      !isa_req_valid_i |=> !isa_forward_pci_o && !isa_keep_isa_o;
   endproperty
   a_idle_isa: assert property (p_idle_isa) else $error("ISA answer with no request.");

   // Writes to 512-640 KB follow the write enable alone.
   property p_mid_write;
      pci_req_valid_i && pci_write_i && (pci_addr_i[31:17] == 15'h0004) && mcs_ctrl_r[`BMD_CTRL_MASTER]
         && mcs_ctrl_r[`BMD_CTRL_MID_WE] && !chk_in_hole |=> !main_memory_select_n_o;
   endproperty
   a_mid_write: assert property (p_mid_write) else $error("Enabled 512-640 KB write not selected.");

   property p_vga_fwd;
      isa_req_valid_i && (isa_addr_i[31:17] == 15'h0005) |=> isa_forward_pci_o == $past(isa_fwd_ctrl_r[2]);
   endproperty
   a_vga_fwd: assert property (p_vga_fwd) else $error("Video memory forward mismatch.");

   cover_select: cover property (pci_req_valid_i ##1 !main_memory_select_n_o);
   cover_forward: cover property (isa_req_valid_i ##1 isa_forward_pci_o);
   cover_hole: cover property (pci_req_valid_i && chk_in_hole && mcs_ctrl_r[`BMD_CTRL_MASTER]);
   cover_slverr: cover property (psel_i && penable_i && pready_o && pslverr_o);
   cover_keep: cover property (isa_req_valid_i ##1 isa_keep_isa_o);
endmodule

// ---- bmd_defs.svh ----
// Purpose: Register indices, field positions, reset values and address tags of the memory address decoder.
// Assumes: Register byte address is four times the register index.
// Notes: Definitions only.
`ifndef BMD_DEFS_SVH
`define BMD_DEFS_SVH

// Register indices; the byte address is the index times four.
`define BMD_IDX_MCS_CTRL 8'h44
`define BMD_IDX_MCS_HOLE_BOT 8'h45
`define BMD_IDX_MCS_HOLE_TOP 8'h46
`define BMD_IDX_MCS_TOM 8'h47
`define BMD_IDX_ISA_FWD_CTRL 8'h48
`define BMD_IDX_ISA_ROM_EN 8'h49
`define BMD_IDX_ISA_HOLE_BOT 8'h4A
`define BMD_IDX_ISA_HOLE_TOP 8'h4B
`define BMD_IDX_DECODE_AUX 8'h50
`define BMD_IDX_DECODE_STATUS 8'h51

// Reset values.
`define BMD_RST_MCS_CTRL 8'h00
`define BMD_RST_HOLE_BOT 8'h10
`define BMD_RST_HOLE_TOP 8'h0F
`define BMD_RST_MCS_TOM 8'h00
`define BMD_RST_ISA_FWD_CTRL 8'h01
`define BMD_RST_ISA_ROM_EN 8'h00
`define BMD_RST_DECODE_AUX 8'h01

// Field positions.
`define BMD_CTRL_MID_RD 0
`define BMD_CTRL_MID_WE 1
`define BMD_CTRL_BIOS_RD 2
`define BMD_CTRL_BIOS_WE 3
`define BMD_CTRL_MASTER 4
`define BMD_FWD_LOW 0
`define BMD_FWD_MID 1
`define BMD_FWD_VGA 2
`define BMD_FWD_LOW_BIOS 3
`define BMD_AUX_POS_BIOS 0
`define BMD_AUX_BOOT_ROM 1

// Address tags of the fixed segments below 1 MB.
`define BMD_TAG_LOW_512K 13'h0000
`define BMD_TAG_MID_128K 15'h0004
`define BMD_TAG_VGA_128K 15'h0005
`define BMD_TAG_ROM_128K 15'h0006
`define BMD_TAG_LOW_BIOS 16'h000E
`define BMD_TAG_UPPER_BIOS 16'h000F
`endif

// ---- bmd_pkg.sv ----
// Purpose: Types shared by the memory address decoder and its bench.
// Assumes: 32-bit addresses and APB data.
// Notes: Constants live in bmd_defs.svh.
package bmd_pkg;
   typedef logic [31:0] bmd_word_type;
   typedef logic [7:0] bmd_reg_type;
   // APB slave phase, Gray coded along idle, setup, access.
   typedef enum logic [1:0]
   {
      BMD_PH_IDLE = 2'b00,
      BMD_PH_SETUP = 2'b01,
      BMD_PH_ACCESS = 2'b11
   } bmd_phase_type;
endpackage

// ---- bmd_far_model.sv ----
// Purpose: Far-side model that presents PCI master accesses and ISA master cycles to the decoder.
// Assumes: The decoder answers one clock after it samples a request.
// Notes: Released address lines carry the inverted last value, so a stale address never matches.
`timescale 1ns/1ps
module bmd_far_model
(
   input wire logic clock_i,
   input wire logic main_memory_select_n_i,
   input wire logic isa_forward_pci_i,
   input wire logic isa_keep_isa_i,
   output logic pci_req_valid_o,
   output logic pci_write_o,
   output bmd_pkg::bmd_word_type pci_addr_o,
   output logic isa_req_valid_o,
   output bmd_pkg::bmd_word_type isa_addr_o
);
   import bmd_pkg::*;
   // Both request paths start idle with a junk address on the lines.
   initial
   begin
      pci_req_valid_o = 1'b0;
      pci_write_o = 1'b0;
      pci_addr_o = 32'h5A5A5A5A;
      isa_req_valid_o = 1'b0;
      isa_addr_o = 32'hA5A5A5A5;
   end
   // One-cycle PCI access after some idle cycles; the lines keep changing while released.
   task automatic pci_access(input bit wr, input bmd_word_type a, input bit [1:0] idle, output logic sel);
      repeat (idle) @(posedge clock_i) pci_addr_o <= ~pci_addr_o;
      @(posedge clock_i);
      pci_req_valid_o <= 1'b1;
      pci_write_o <= wr;
      pci_addr_o <= a;
      @(posedge clock_i);
      pci_req_valid_o <= 1'b0;
      pci_write_o <= ~wr;
      pci_addr_o <= ~a;
      @(negedge clock_i);
      sel = ~main_memory_select_n_i;
   endtask
   // One-cycle ISA or DMA memory cycle; both answers are taken one clock later.
   task automatic isa_access(input bmd_word_type a, input bit [1:0] idle, output logic f, output logic k);
      repeat (idle) @(posedge clock_i) isa_addr_o <= ~isa_addr_o;
      @(posedge clock_i);
      isa_req_valid_o <= 1'b1;
      isa_addr_o <= a;
      @(posedge clock_i);
      isa_req_valid_o <= 1'b0;
      isa_addr_o <= ~a;
      @(negedge clock_i);
      f = isa_forward_pci_i;
      k = isa_keep_isa_i;
   endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the memory address decoder against a behavioural model.
// Assumes: Zero-wait APB slave; decode outputs follow requests by one clock.
// Notes: Random stimulus comes from an xorshift generator with a fixed seed.
`timescale 1ns/1ps
`include "bmd_defs.svh"
module tb_top;
   import bmd_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   bmd_word_type paddr = '0;
   bmd_word_type pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, pci_valid, pci_wr, sel_n, bios_pos, isa_valid, fwd, keep;
   bmd_word_type prdata, pci_addr, isa_addr;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   bit [31:0] seed = 32'hA3EF83F7;
   bit [7:0] m_reg [8'h44:8'h51];
   localparam bit [31:0] seg_tab [7] = '{32'h7FFFF, 32'h80000, 32'h9FFFF, 32'hA0000, 32'hEFFFF, 32'hF0000, 32'hFFFFF};
   localparam bit [31:0] isa_tab [10] = '{32'h0, 32'h7FFFF, 32'h80000, 32'h9FFFF, 32'hA0000, 32'hBFFFF,
      32'hC0000, 32'hE0000, 32'hEFFFF, 32'hF0000};
   localparam bit [31:0] tom_tab [6] = '{32'h1FFFFF, 32'h200000, 32'h3FFFFF, 32'h400000, 32'h1FFFFFFF, 32'h20000000};
   localparam bit [31:0] ih_tab [6] = '{32'h1FFFFF, 32'h200000, 32'h21FFFF, 32'h220000, 32'hF0FFFF, 32'h1200000};
   localparam bit [31:0] msk [4] = '{32'hFFFFF, 32'hFFFFFF, 32'h1FFFFFFF, 32'hFFFFFFFF};

   bmd_decode i_bmd_decode (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
      .prdata_o(prdata), .pslverr_o(pslverr), .pci_req_valid_i(pci_valid), .pci_write_i(pci_wr),
      .pci_addr_i(pci_addr), .main_memory_select_n_o(sel_n), .bios_positive_decode_o(bios_pos),
      .isa_req_valid_i(isa_valid), .isa_addr_i(isa_addr), .isa_forward_pci_o(fwd), .isa_keep_isa_o(keep));
   bmd_far_model i_bmd_far_model (.clock_i(clock_i), .main_memory_select_n_i(sel_n), .isa_forward_pci_i(fwd),
      .isa_keep_isa_i(keep), .pci_req_valid_o(pci_valid), .pci_write_o(pci_wr), .pci_addr_o(pci_addr),
      .isa_req_valid_o(isa_valid), .isa_addr_o(isa_addr));

   // Free-running 10 MHz clock.
   initial
   begin
      forever #50 clock_i = ~clock_i;
   end
   // A hang is cut short well above the roughly ten thousand cycles the tests need.
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         error_cnt++;
         $display("ERROR at %0t ns: timeout, got %08h expected %08h", $time, cycles, 0);
         results();
      end
   end

   function automatic bit [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic bit mapped(input bit [7:0] idx);
      return idx inside {[8'h44:8'h4B], 8'h50, 8'h51};
   endfunction
   function automatic bit in_rng(input bit [31:0] a, input bit [31:0] lo, input bit [31:0] hi);
      return a >= lo && a <= hi;
   endfunction
   // Model of the memory select: master gate, fixed segments, top of memory, hole.
   function automatic bit m_sel(input bit wr, input bit [31:0] a);
      bit [7:0] c;
      bit rgn;
      bit hole;
      c = m_reg[8'h44];
      hole = a[31:24] == 8'h00 && a[23:16] >= m_reg[8'h45] && a[23:16] <= m_reg[8'h46];
      rgn = a < 32'h80000 || (in_rng(a, 32'h80000, 32'h9FFFF) && c[wr]) || (in_rng(a, 32'hF0000, 32'hFFFFF) && c[2 + wr])
         || (a[31:29] == 3'h0 && a[28:21] != 8'h00 && a[28:21] <= m_reg[8'h47]);
      return c[4] && rgn && !hole;
   endfunction
   // Model of ISA forwarding; the ROM block index is address bits 16 to 14.
   function automatic bit m_fwd(input bit [31:0] a);
      bit [7:0] f;
      bit ih;
      f = m_reg[8'h48];
      ih = a[23:16] >= m_reg[8'h4A] && a[23:16] <= m_reg[8'h4B];
      return (a[31:24] == 8'h00 && a[23:20] != 4'h0 && a[23:20] <= f[7:4] && !ih) || (a < 32'h80000 && f[0])
         || (in_rng(a, 32'h80000, 32'h9FFFF) && f[1]) || (in_rng(a, 32'hA0000, 32'hBFFFF) && f[2])
         || (in_rng(a, 32'hE0000, 32'hEFFFF) && f[3] && !m_reg[8'h50][1])
         || (in_rng(a, 32'hC0000, 32'hDFFFF) && m_reg[8'h49][a[16:14]]);
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR at %0t ns: got %08h expected %08h", $time, got, exp);
      end
   endtask
   // APB transfer: setup, then access held until pready is sampled high.
   task automatic apb(input bit wr, input bit [7:0] idx, input bit [7:0] d, input bit [3:0] st,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= (rnd() & 32'hFFFFFF00) | {24'h0, d};
      pstrb <= st;
      @(posedge clock_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cmp(n, 1);
   endtask
   task automatic wr_reg(input bit [7:0] idx, input bit [7:0] d, input bit [3:0] st = 4'h1);
      logic [31:0] rd;
      logic err;
      bit bad;
      bad = !mapped(idx) || idx == 8'h51;
      apb(1'b1, idx, d, st, rd, err);
      cmp({31'h0, err}, {31'h0, bad});
      if (!bad && st[0])
         m_reg[idx] = d & (idx == 8'h44 ? 8'h1F : idx == 8'h50 ? 8'h03 : 8'hFF);
   endtask
   task automatic rd_reg(input bit [7:0] idx);
      logic [31:0] rd;
      logic err;
      apb(1'b0, idx, 8'h00, 4'h0, rd, err);
      cmp({31'h0, err}, {31'h0, !mapped(idx)});
      cmp(rd, mapped(idx) ? {24'h0, m_reg[idx]} : 32'h0);
   endtask
   task automatic pci(input bit wr, input bit [31:0] a);
      logic s;
      i_bmd_far_model.pci_access(wr, a, seed[1:0], s);
      cmp({31'h0, s}, {31'h0, m_sel(wr, a)});
      cmp({31'h0, bios_pos}, {31'h0, m_reg[8'h50][0] & ~m_reg[8'h44][4]});
   endtask
   task automatic isa(input bit [31:0] a);
      logic f, k;
      i_bmd_far_model.isa_access(a, seed[2:1], f, k);
      cmp({31'h0, f}, {31'h0, m_fwd(a)});
      cmp({31'h0, k}, {31'h0, !m_fwd(a)});
   endtask
   task automatic test_end(input string name);
      $display("Test %s ended with %0d mismatches so far", name, error_cnt);
   endtask
   task automatic results();
      $display("Compares %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence: reset, register file, PCI decode, ISA decode, random mix.
   initial
   begin
      int i, j, k;
      bit [7:0] d, idx;
      bit [31:0] r;
      foreach (m_reg[n]) m_reg[n] = 8'h00;
      m_reg[8'h45] = 8'h10;
      m_reg[8'h46] = 8'h0F;
      m_reg[8'h48] = 8'h01;
      m_reg[8'h4A] = 8'h10;
      m_reg[8'h4B] = 8'h0F;
      m_reg[8'h50] = 8'h01;
      repeat (3) @(posedge clock_i);
      cmp({sel_n, bios_pos, pready}, 3'b110);
      rst_n_i <= 1'b1;
      for (i = 8'h44; i <= 8'h51; i++) rd_reg(i[7:0]);
      wr_reg(8'h44, 8'hFF);
      wr_reg(8'h51, 8'hFF);
      wr_reg(8'h45, 8'hAA, 4'hE);
      for (i = 8'h44; i <= 8'h46; i++) rd_reg(i[7:0]);
      test_end("registers");
      for (i = 0; i < 32; i++)
      begin
         wr_reg(8'h44, {3'h0, i[4:0]});
         for (j = 0; j < 14; j++) pci(j[0], seg_tab[j / 2]);
      end
      for (i = 0; i < 3; i++)
      begin
         wr_reg(8'h47, i == 0 ? 8'h00 : i == 1 ? 8'h01 : 8'hFF);
         for (j = 0; j < 6; j++) pci(1'b0, tom_tab[j]);
      end
      for (i = 0; i < 3; i++)
      begin
         wr_reg(8'h45, i == 1 ? 8'h22 : 8'h20);
         wr_reg(8'h46, i == 2 ? 8'h20 : 8'h21);
         for (j = 0; j < 6; j++) pci(1'b1, ih_tab[j]);
      end
      test_end("pci decode");
      for (i = 0; i < 64; i++)
      begin
         wr_reg(8'h48, {4'h0, i[3:0]});
         wr_reg(8'h50, {6'h0, i[5:4]});
         for (j = 0; j < 10; j++) isa(isa_tab[j]);
      end
      for (i = 0; i < 8; i++)
      begin
         wr_reg(8'h49, 8'h01 << i);
         for (j = 0; j < 8; j++) isa(32'hC0000 + j * 32'h4000);
      end
      for (i = 0; i < 16; i++)
      begin
         wr_reg(8'h48, {i[3:0], 4'h0});
         for (j = 0; j < 3; j++) isa(((i + j / 2) << 20) - j % 2);
      end
      for (i = 0; i < 2; i++)
      begin
         wr_reg(8'h4A, i == 0 ? 8'h20 : 8'hF0);
         wr_reg(8'h4B, i == 0 ? 8'h21 : 8'hF0);
         for (j = 0; j < 6; j++) isa(ih_tab[j]);
      end
      test_end("isa decode");
      for (i = 0; i < 300; i++)
      begin
         r = rnd();
         idx = r[4:3] == 2'h3 ? 8'h50 : 8'h44 + {5'h0, r[2:0]};
         d = r[15:8];
         if (idx inside {8'h45, 8'h46, 8'h4A, 8'h4B} && d < 8'h10)
            d = 8'h10;
         wr_reg(idx, d);
         for (k = 0; k < 2; k++)
         begin
            r = rnd();
            pci(r[2], rnd() & msk[r[1:0]]);
            isa(rnd() & msk[r[4:3]]);
         end
      end
      test_end("random");
      results();
   end
endmodule
